/* File: tir_pkg.sv */
// Constants, register map and types for the timing input routing block
// Assumes an APB master on core_clk_in and a 100 MHz clock
//
// Summary of operation
// - Ten bidirectional function pins carry timing control
// - Each of 13 signals selects its pin
// - Per-pin driver enable, fixed internal signal out
// - Per-pin polarity; detection set by signal
// - Five output-only pins for remaining signals
// - Digital port line groups set in/out
// - Digital port clock from one selectable source
// - Counter or external clock passes backplane line
// - Separate edge choice for input/output groups
// - Each scan begin gives one conversion pulse
// - Post-trigger mode keeps samples after trigger
// - Pre-trigger mode keeps samples before and after
// - Start trigger edge starts acquisition, both modes
// - Marker ignored until count zero, then reload
// - Trigger outputs 25-50 ns high, off at start
package tir_pkg;
  localparam int         PIN_NUM       = 10;
  localparam int         SIG_NUM       = 13;
  localparam int         DED_NUM       = 5;
  localparam int         DIO_NUM       = 8;
  localparam int         BPL_NUM       = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PIN_OE    = 8'h04;
  localparam logic [7:0] OFS_PIN_POL   = 8'h08;
  localparam logic [7:0] OFS_DIO_DIR   = 8'h0c;
  localparam logic [7:0] OFS_DIO_CLK   = 8'h10;
  localparam logic [7:0] OFS_PRE_CNT   = 8'h14;
  localparam logic [7:0] OFS_POST_CNT  = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  localparam logic [7:0] OFS_DIO_DATA  = 8'h20;
  localparam logic [7:0] OFS_SEL_BASE  = 8'h40;
  // CTRL fields
  localparam int         CTRL_PRE_BIT  = 0;
  localparam int         CTRL_ARM_BIT  = 1;
  localparam int         CTRL_SWT_BIT  = 2;
  // DIO_CLK fields
  localparam int         CLK_SRC_LSB   = 0;
  localparam int         CLK_BPL_LSB   = 4;
  localparam int         CLK_IEDGE_BIT = 8;
  localparam int         CLK_OEDGE_BIT = 9;
  // Selector code: 0 internal, 1..10 pin index+1
  localparam logic [3:0] SEL_INTERNAL  = 4'h0;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  // Timing signal indexes
  localparam int         SIG_START     = 0;
  localparam int         SIG_MARKER    = 1;
  localparam int         SIG_SCAN      = 2;
  localparam int         SIG_CONV      = 3;
  localparam int         SIG_GATE      = 4;
  localparam int         SIG_SICLK     = 5;
  // Level detected signals mask (gate, scan interval clock)
  localparam logic [12:0] LEVEL_MASK   = 13'h0030;
  // Trigger output pulse width
  localparam int         CLK_NS        = 10;
  localparam int         PULSE_MIN_NS  = 25;
  localparam int         PULSE_CYC     = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    TIR_CLK_SCAN = 3'b000,
    TIR_CLK_AOUT = 3'b001,
    TIR_CLK_CTR0 = 3'b010,
    TIR_CLK_CTR1 = 3'b011,
    TIR_CLK_BPL  = 3'b100,
    TIR_CLK_EXT  = 3'b101
  } tir_clk_src_t;
  typedef enum logic [1:0] {
    TIR_IDLE = 2'b00,
    TIR_PRE  = 2'b01,
    TIR_WAIT = 2'b10,
    TIR_POST = 2'b11
  } tir_state_t;
endpackage

/* File: tir_pulse_gen.sv */
// Stretches a one-cycle event into a fixed-width high pulse
// Assumes the event is synchronous to core_clk_in
`timescale 1ns/10ps
module tir_pulse_gen (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  input  wire logic trig_in,
  output logic      pulse_out
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  // Reload on event, count down to zero
  assign nxt_cnt = trig_in ? 3'(tir_pkg::PULSE_CYC) : ((cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_ff    <= 3'h0;
      pulse_out <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      pulse_out <= (nxt_cnt != 3'h0);
    end
  end
endmodule

/* File: tir_top.sv */
// Timing input routing: function pins, timing signal selection, digital port clock
// Assumes APB master on core_clk_in; pins and backplane lines are asynchronous
`timescale 1ns/10ps
module tir_top (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Function pins
  input  wire logic [9:0]  function_pin_in,
  output logic      [9:0]  function_pin_out,
  output logic      [9:0]  function_pin_oe_out,
  // Internal sources and fixed outputs
  input  wire logic [12:0] int_timing_in,
  input  wire logic [4:0]  ded_timing_in,
  output logic      [4:0]  ded_timing_out,
  output logic      [12:0] timing_sig_out,
  // Acquisition
  output logic             scan_begin_pulse_out,
  output logic             convert_pulse_out,
  output logic             sample_keep_out,
  output logic             acq_active_out,
  // Digital port
  input  wire logic        analog_in_scan_begin_in,
  input  wire logic        analog_out_refresh_in,
  input  wire logic [1:0]  general_counter_in,
  input  wire logic        counter_zero_output_in,
  input  wire logic [5:0]  backplane_trigger_lines_in,
  output logic      [5:0]  backplane_trigger_lines_out,
  output logic      [5:0]  backplane_trigger_lines_oe_out,
  input  wire logic [7:0]  digital_port_lines_in,
  output logic      [7:0]  digital_port_lines_out,
  output logic      [7:0]  digital_port_lines_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and synchronisers
  logic [31:0] ctrl_ff, pin_oe_ff, pin_pol_ff, dio_dir_ff, dio_clk_ff, dio_do_ff;
  logic [15:0] pre_cnt_ff, post_cnt_ff, scan_cnt_ff;
  logic [3:0]  sel_ff [13];
  logic [9:0]  pin_s1_ff, pin_s2_ff, pin_d_ff;
  logic [5:0]  bpl_s1_ff, bpl_s2_ff;
  logic [4:0]  ext_s1_ff, ext_s2_ff;   // Scan, refresh, counters, counter zero
  logic [7:0]  dio_s1_ff, dio_s2_ff, dio_di_ff;
  logic        dclk_d_ff, swt_ff;
  tir_pkg::tir_state_t state_ff, nxt_state;

  // Polarity is applied after the synchroniser
  function automatic logic pick(input logic [3:0] sel, input logic [9:0] lvl, input logic intl);
    pick = (sel == tir_pkg::SEL_INTERNAL || sel > 4'd10) ? intl : lvl[sel - 4'h1];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire         wr_en  = psel & penable & pwrite;
  wire         sel_hit = (paddr >= tir_pkg::OFS_SEL_BASE) && (paddr < tir_pkg::OFS_SEL_BASE + 8'd52);
  wire [7:0]   sel_off = paddr - tir_pkg::OFS_SEL_BASE;
  wire [3:0]   sel_idx = sel_off[5:2];
  wire         map_hit = sel_hit || (paddr <= tir_pkg::OFS_DIO_DATA);
  wire         bad     = (paddr[1:0] != 2'b00) || !map_hit;
  logic [31:0] rd_mux;

  // Read selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_hit) rd_mux = {28'h0, sel_ff[sel_idx]};
    else begin
      case (paddr)
        tir_pkg::OFS_CTRL:     rd_mux = ctrl_ff;
        tir_pkg::OFS_PIN_OE:   rd_mux = pin_oe_ff;
        tir_pkg::OFS_PIN_POL:  rd_mux = pin_pol_ff;
        tir_pkg::OFS_DIO_DIR:  rd_mux = dio_dir_ff;
        tir_pkg::OFS_DIO_CLK:  rd_mux = dio_clk_ff;
        tir_pkg::OFS_PRE_CNT:  rd_mux = {16'h0, pre_cnt_ff};
        tir_pkg::OFS_POST_CNT: rd_mux = {16'h0, post_cnt_ff};
        tir_pkg::OFS_STATUS:   rd_mux = {14'h0, scan_cnt_ff, state_ff};
        tir_pkg::OFS_DIO_DATA: rd_mux = {16'h0, dio_di_ff, dio_do_ff[7:0]};
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Register writes; reset selects internal sources, drivers off
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_ff     <= tir_pkg::RST_ZERO;
      pin_oe_ff   <= tir_pkg::RST_ZERO;
      pin_pol_ff  <= tir_pkg::RST_ZERO;
      dio_dir_ff  <= tir_pkg::RST_ZERO;
      dio_clk_ff  <= tir_pkg::RST_ZERO;
      dio_do_ff   <= tir_pkg::RST_ZERO;
      pre_cnt_ff  <= tir_pkg::RST_COUNT;
      post_cnt_ff <= tir_pkg::RST_COUNT;
      for (int i = 0; i < tir_pkg::SIG_NUM; i++) sel_ff[i] <= tir_pkg::SEL_INTERNAL;
    end else if (wr_en && !bad) begin
      if (sel_hit) sel_ff[sel_idx] <= pwdata[3:0];
      else begin
        case (paddr)
          tir_pkg::OFS_CTRL:     ctrl_ff     <= {29'h0, pwdata[2:0]};
          tir_pkg::OFS_PIN_OE:   pin_oe_ff   <= {22'h0, pwdata[9:0]};
          tir_pkg::OFS_PIN_POL:  pin_pol_ff  <= {22'h0, pwdata[9:0]};
          tir_pkg::OFS_DIO_DIR:  dio_dir_ff  <= {30'h0, pwdata[1:0]};
          tir_pkg::OFS_DIO_CLK:  dio_clk_ff  <= {22'h0, pwdata[9:0]};
          tir_pkg::OFS_PRE_CNT:  pre_cnt_ff  <= pwdata[15:0];
          tir_pkg::OFS_POST_CNT: post_cnt_ff <= pwdata[15:0];
          tir_pkg::OFS_DIO_DATA: dio_do_ff   <= {24'h0, pwdata[7:0]};
          default:               ctrl_ff     <= ctrl_ff;
        endcase
      end
    end
  end

  // Zero-wait APB answer
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & !penable;
      pslverr <= psel & !penable & bad;
      prdata  <= (psel & !penable & !pwrite & !bad) ? rd_mux : 32'h0000_0000;
    end
  end
  // Note: access phase completes one cycle after setup with pready registered

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1_ff <= 10'h3ff;
      pin_s2_ff <= 10'h3ff;
      pin_d_ff  <= 10'h3ff;  // Pull-up idle level, no edge after reset
      bpl_s1_ff <= 6'h00;
      bpl_s2_ff <= 6'h00;
      ext_s1_ff <= 5'h00;
      ext_s2_ff <= 5'h00;
      dio_s1_ff <= 8'h00;
      dio_s2_ff <= 8'h00;
    end else begin
      pin_s1_ff <= function_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff ^ pin_pol_ff[9:0];
      bpl_s1_ff <= backplane_trigger_lines_in;
      bpl_s2_ff <= bpl_s1_ff;
      ext_s1_ff <= {counter_zero_output_in, general_counter_in, analog_out_refresh_in, analog_in_scan_begin_in};
      ext_s2_ff <= ext_s1_ff;
      dio_s1_ff <= digital_port_lines_in;
      dio_s2_ff <= dio_s1_ff;
    end
  end

  wire [9:0]  pin_lvl  = pin_s2_ff ^ pin_pol_ff[9:0];
  wire [9:0]  pin_edge = pin_lvl & ~pin_d_ff;
  logic [12:0] nxt_sig;

  // Per-signal source pick; level or edge by signal type
  always_comb begin
    for (int i = 0; i < tir_pkg::SIG_NUM; i++) begin
      nxt_sig[i] = pick(sel_ff[i], tir_pkg::LEVEL_MASK[i] ? pin_lvl : pin_edge, int_timing_in[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer
  wire start_ev  = nxt_sig[tir_pkg::SIG_START] | (ctrl_ff[tir_pkg::CTRL_SWT_BIT] & !swt_ff);
  wire marker_ev = nxt_sig[tir_pkg::SIG_MARKER];
  wire scan_ev   = nxt_sig[tir_pkg::SIG_SCAN] & !nxt_sig[tir_pkg::SIG_GATE] & (state_ff != tir_pkg::TIR_IDLE);
  logic [15:0] nxt_cnt;

  // State and scan counter next values
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = scan_cnt_ff;
    case (state_ff)
      tir_pkg::TIR_IDLE: if (start_ev && ctrl_ff[tir_pkg::CTRL_ARM_BIT]) begin
        nxt_state = ctrl_ff[tir_pkg::CTRL_PRE_BIT] ? tir_pkg::TIR_PRE : tir_pkg::TIR_POST;
        nxt_cnt   = ctrl_ff[tir_pkg::CTRL_PRE_BIT] ? pre_cnt_ff : post_cnt_ff;
      end
      tir_pkg::TIR_PRE: if (scan_ev) begin
        if (scan_cnt_ff <= 16'h0001) begin
          nxt_state = tir_pkg::TIR_WAIT;
          nxt_cnt   = post_cnt_ff;
        end else nxt_cnt = scan_cnt_ff - 16'h0001;
      end
      tir_pkg::TIR_WAIT: if (marker_ev) nxt_state = tir_pkg::TIR_POST;
      tir_pkg::TIR_POST: if (scan_ev) begin
        if (scan_cnt_ff <= 16'h0001) nxt_state = tir_pkg::TIR_IDLE;
        nxt_cnt = (scan_cnt_ff == 16'h0000) ? 16'h0000 : scan_cnt_ff - 16'h0001;
      end
      default: nxt_state = tir_pkg::TIR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff             <= tir_pkg::TIR_IDLE;
      scan_cnt_ff          <= tir_pkg::RST_COUNT;
      swt_ff               <= 1'b0;
      timing_sig_out       <= 13'h0000;
      scan_begin_pulse_out <= 1'b0;
      convert_pulse_out    <= 1'b0;
      sample_keep_out      <= 1'b0;
      acq_active_out       <= 1'b0;
    end else begin
      state_ff             <= nxt_state;
      scan_cnt_ff          <= nxt_cnt;
      swt_ff               <= ctrl_ff[tir_pkg::CTRL_SWT_BIT];
      timing_sig_out       <= nxt_sig;
      scan_begin_pulse_out <= scan_ev;
      convert_pulse_out    <= scan_ev;
      // Post mode keeps after trigger; pre mode keeps all scans
      sample_keep_out      <= scan_ev;
      acq_active_out       <= (nxt_state != tir_pkg::TIR_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function pin outputs: fixed signal per pin, start and marker pulsed
  logic        p_start, p_marker;
  tir_pulse_gen u_start_pulse (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .trig_in     (start_ev & (state_ff == tir_pkg::TIR_IDLE) & ctrl_ff[tir_pkg::CTRL_ARM_BIT]),
    .pulse_out   (p_start)
  );
  tir_pulse_gen u_marker_pulse (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .trig_in     (marker_ev & (state_ff == tir_pkg::TIR_WAIT)),
    .pulse_out   (p_marker)
  );

  // Outside party keeps off enabled pins; driver and enable registered
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      function_pin_out    <= 10'h000;
      function_pin_oe_out <= 10'h000;
      ded_timing_out      <= 5'h00;
    end else begin
      function_pin_out    <= {int_timing_in[9:2], p_marker, p_start};
      function_pin_oe_out <= pin_oe_ff[9:0];
      ded_timing_out      <= ded_timing_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital port clock select and transfers
  wire [2:0] csrc   = dio_clk_ff[tir_pkg::CLK_SRC_LSB +: 3];
  wire [2:0] bsel   = dio_clk_ff[tir_pkg::CLK_BPL_LSB +: 3];
  wire       bpl_ok = (bsel < 3'd6);
  logic      dclk;

  // Counter and external clocks travel over a backplane line
  always_comb begin
    case (csrc)
      tir_pkg::TIR_CLK_SCAN: dclk = ext_s2_ff[0];
      tir_pkg::TIR_CLK_AOUT: dclk = ext_s2_ff[1];
      tir_pkg::TIR_CLK_BPL,
      tir_pkg::TIR_CLK_CTR0,
      tir_pkg::TIR_CLK_CTR1,
      tir_pkg::TIR_CLK_EXT:  dclk = bpl_ok ? bpl_s2_ff[bsel] : 1'b0;
      default:               dclk = 1'b0;
    endcase
  end

  wire  dclk_rise = dclk & !dclk_d_ff;
  wire  dclk_fall = !dclk & dclk_d_ff;
  wire  di_tick   = dio_clk_ff[tir_pkg::CLK_IEDGE_BIT] ? dclk_fall : dclk_rise;
  wire  do_tick   = dio_clk_ff[tir_pkg::CLK_OEDGE_BIT] ? dclk_fall : dclk_rise;
  logic [5:0] nxt_bpl;
  wire  drive_bpl = bpl_ok & ((csrc == tir_pkg::TIR_CLK_CTR0) | (csrc == tir_pkg::TIR_CLK_CTR1) |
                              (csrc == tir_pkg::TIR_CLK_EXT));
  wire  bpl_src   = (csrc == tir_pkg::TIR_CLK_CTR0) ? ext_s2_ff[2] :
                    (csrc == tir_pkg::TIR_CLK_CTR1) ? ext_s2_ff[3] : ext_s2_ff[4];
  assign nxt_bpl  = drive_bpl ? (6'h01 << bsel) : 6'h00;
  wire [7:0] grp_oe = {{4{dio_dir_ff[1]}}, {4{dio_dir_ff[0]}}};

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dclk_d_ff                      <= 1'b0;
      dio_di_ff                      <= 8'h00;
      digital_port_lines_out         <= 8'h00;
      digital_port_lines_oe_out      <= 8'h00;
      backplane_trigger_lines_out    <= 6'h00;
      backplane_trigger_lines_oe_out <= 6'h00;
    end else begin
      dclk_d_ff                 <= dclk;
      digital_port_lines_oe_out <= grp_oe;
      if (di_tick) dio_di_ff <= dio_s2_ff & ~grp_oe;
      if (do_tick) digital_port_lines_out <= dio_do_ff[7:0] & grp_oe;
      backplane_trigger_lines_out    <= drive_bpl ? ({6{bpl_src}} & nxt_bpl) : 6'h00;
      backplane_trigger_lines_oe_out <= nxt_bpl;
    end
  end
endmodule

/* File: tir_assertions.sv */
// Port-level checker for the timing input routing block
// Assumes it is bound onto tir_top and that there is a single clock domain
`timescale 1ns/10ps
module tir_assertions (
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  input wire logic [9:0]  function_pin_out,
  input wire logic [9:0]  function_pin_oe_out,
  input wire logic [12:0] int_timing_in,
  input wire logic [4:0]  ded_timing_in,
  input wire logic [4:0]  ded_timing_out,
  input wire logic [12:0] timing_sig_out,
  input wire logic        scan_begin_pulse_out,
  input wire logic        convert_pulse_out,
  input wire logic        sample_keep_out,
  input wire logic        acq_active_out,
  input wire logic [7:0]  digital_port_lines_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////
  // Drivers off after reset, trigger pulse width
  property p_drv_off;
    !$past(rstn_in) |-> function_pin_oe_out == 10'h000;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("pin driver on after reset");
  property p_start_width;
    $rose(function_pin_out[0]) |-> function_pin_out[0] [*3] ##1 !function_pin_out[0];
  endproperty
  a_start_width: assert property (p_start_width) else $error("start pulse width wrong");
  property p_marker_width;
    $rose(function_pin_out[1]) |-> function_pin_out[1] [*3] ##1 !function_pin_out[1];
  endproperty
  a_marker_width: assert property (p_marker_width) else $error("marker pulse width wrong");
  // Conversion within two cycles of each scan, keep only inside a sequence
  property p_conv;
    scan_begin_pulse_out |-> ##[0:2] convert_pulse_out;
  endproperty
  a_conv: assert property (p_conv) else $error("scan without conversion");
  property p_keep;
    sample_keep_out |-> acq_active_out || $past(acq_active_out);
  endproperty
  a_keep: assert property (p_keep) else $error("sample kept outside acquisition");
  // Start signal becomes single-cycle pulses
  property p_edge;
    timing_sig_out[tir_pkg::SIG_START] |=> !timing_sig_out[tir_pkg::SIG_START];
  endproperty
  a_edge: assert property (p_edge) else $error("start signal wider than a cycle");
  // Fixed pin outputs and dedicated outputs follow their sources; port direction set per group
  property p_pin_fixed;
    $past(rstn_in) |-> function_pin_out[9:2] == $past(int_timing_in[9:2]);
  endproperty
  a_pin_fixed: assert property (p_pin_fixed) else $error("pin output not its fixed signal");
  property p_ded;
    $past(rstn_in) |-> ded_timing_out == $past(ded_timing_in);
  endproperty
  a_ded: assert property (p_ded) else $error("dedicated output wrong");
  property p_dio_grp;
    digital_port_lines_oe_out[3:0] inside {4'h0, 4'hf} && digital_port_lines_oe_out[7:4] inside {4'h0, 4'hf};
  endproperty
  a_dio_grp: assert property (p_dio_grp) else $error("port direction split inside group");
endmodule
bind tir_top tir_assertions u_chk (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .function_pin_out(function_pin_out),
  .function_pin_oe_out(function_pin_oe_out), .int_timing_in(int_timing_in), .ded_timing_in(ded_timing_in),
  .ded_timing_out(ded_timing_out), .timing_sig_out(timing_sig_out), .scan_begin_pulse_out(scan_begin_pulse_out),
  .convert_pulse_out(convert_pulse_out), .sample_keep_out(sample_keep_out), .acq_active_out(acq_active_out),
  .digital_port_lines_oe_out(digital_port_lines_oe_out)
);

/* File: tir_ext_src.sv */
// Outside trigger equipment on the function pins and counter zero output
// Assumes pulled-up pins when nobody drives them
`timescale 1ns/10ps
module tir_ext_src (
  input  wire logic [9:0] pin_oe_in,
  input  wire logic [9:0] pin_drv_in,
  input  wire logic [9:0] ext_en_in,
  input  wire logic [9:0] ext_val_in,
  input  wire logic       ctr0_en_in,
  input  wire logic       ctr0_val_in,
  output logic      [9:0] pin_level_out,
  output logic            ctr0_level_out
);
  // Equipment backs off where the block drives; elsewhere it drives when enabled, pull-up when not
  assign pin_level_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ~ext_en_in) | (~pin_oe_in & ext_val_in);
  // Outside clock only on counter zero output
  assign ctr0_level_out = ctr0_en_in ? ctr0_val_in : 1'b1;
endmodule

/* File: tb_top.sv */
// Self-checking bench for tir_top with outside equipment model
// Assumes 100 MHz clock and APB slave answering on its own pready
`timescale 1ns/10ps
module tb_top;
  logic        core_clk_in = 1'b0;
  logic        rstn_in     = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00, dio_in = 8'h00, dio_out, dio_oe, dv;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  pin_lvl, pin_out, pin_oe, ext_en = 10'h000, ext_val = 10'h000;
  logic [12:0] int_t = 13'h0000, tsig;
  logic [4:0]  ded_in = 5'h00, ded_out;
  logic [5:0]  bpl_out, bpl_oe, bpl_in;
  logic [3:0]  p;
  logic        pol, ai_scan = 1'b0, ctr0_lvl, scan_p, conv_p, keep_p, act;
  int          error_cnt = 0, checks = 0, cyc = 0, sel_mon = 0, tcnt = 0, scnt = 0, ccnt = 0, kcnt = 0, t0, k0, s0;
  int          mdl[int];
  tir_pkg::tir_clk_src_t cs;
  ////////////////////////////////////////
  // Clock, resolved lines, instances
  always #5 core_clk_in = ~core_clk_in;
  assign bpl_in = (bpl_oe & bpl_out) | ~bpl_oe;
  tir_ext_src u_ext (.pin_oe_in(pin_oe), .pin_drv_in(pin_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .ctr0_en_in(1'b0), .ctr0_val_in(1'b0), .pin_level_out(pin_lvl), .ctr0_level_out(ctr0_lvl));
  tir_top u_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .function_pin_in(pin_lvl), .function_pin_out(pin_out), .function_pin_oe_out(pin_oe), .int_timing_in(int_t),
    .ded_timing_in(ded_in), .ded_timing_out(ded_out), .timing_sig_out(tsig), .scan_begin_pulse_out(scan_p),
    .convert_pulse_out(conv_p), .sample_keep_out(keep_p), .acq_active_out(act), .analog_in_scan_begin_in(ai_scan),
    .analog_out_refresh_in(1'b0), .general_counter_in(2'b00), .counter_zero_output_in(ctr0_lvl),
    .backplane_trigger_lines_in(bpl_in), .backplane_trigger_lines_out(bpl_out),
    .backplane_trigger_lines_oe_out(bpl_oe), .digital_port_lines_in(dio_in), .digital_port_lines_out(dio_out),
    .digital_port_lines_oe_out(dio_oe));
  // Pulse counters, random free-running sources, timeout
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (tsig[sel_mon] === 1'b1) tcnt <= tcnt + 1;
    if (scan_p === 1'b1) scnt <= scnt + 1;
    if (conv_p === 1'b1) ccnt <= ccnt + 1;
    if (keep_p === 1'b1) kcnt <= kcnt + 1;
    if (rstn_in) begin
      int_t[12:6] <= 7'($urandom);
      ded_in <= 5'($urandom);
    end
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // One APB transfer; answer taken where pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && er === 1'b0) mdl[a] = d;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, mdl[a] & m);
  endtask
  task automatic ipulse(input int b);
    @(posedge core_clk_in);
    int_t[b] <= 1'b1;
    @(posedge core_clk_in);
    int_t[b] <= 1'b0;
    waitc(6);
  endtask
  task automatic pin_set(input logic [3:0] n, input logic en, input logic v);
    @(posedge core_clk_in);
    ext_en[n] <= en;
    ext_val[n] <= v;
    waitc(8);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h18713d18));
    repeat (4) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    // Reset values and unmapped access
    for (int i = 0; i < 29; i++) mdl[4 * i] = 0;
    for (int i = 0; i < 29; i++) if (i < 9 || i > 15) rchk(8'(4 * i), 32'hffffffff);
    chk(pin_oe, 10'h000);
    apb(1'b1, 8'h30, 32'h5a5a5a5a);
    chk(er, 1'b1);
    apb(1'b0, 8'h41, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test reset done");
    // Driver enables and port direction groups
    apb(1'b1, tir_pkg::OFS_PIN_OE, 32'($urandom_range(1023)));
    rchk(tir_pkg::OFS_PIN_OE, 32'h3ff);
    waitc(2);
    chk(pin_oe, mdl[tir_pkg::OFS_PIN_OE] & 32'h3ff);
    apb(1'b1, tir_pkg::OFS_PIN_OE, 32'h0);
    for (int d = 1; d < 4; d++) begin
      apb(1'b1, tir_pkg::OFS_DIO_DIR, 32'(d));
      waitc(2);
      chk(dio_oe, {{4{d[1]}}, {4{d[0]}}});
    end
    $display("test enables done");
    // Every timing signal from a random pin with random polarity
    for (int s = 0; s < tir_pkg::SIG_NUM; s++) begin
      p = 4'($urandom_range(9));
      pol = 1'($urandom);
      sel_mon = s;
      apb(1'b1, 8'(tir_pkg::OFS_SEL_BASE + 4 * s), 32'(p) + 32'h1);
      apb(1'b1, tir_pkg::OFS_PIN_POL, 32'(pol) << p);
      pin_set(p, 1'b1, pol);
      t0 = tcnt;
      pin_set(p, 1'b1, !pol);
      chk(tir_pkg::LEVEL_MASK[s] ? 32'(tsig[s]) : 32'(tcnt - t0), 32'h1);
      pin_set(p, 1'b1, pol);
      chk(tir_pkg::LEVEL_MASK[s] ? 32'(tsig[s]) : 32'(tcnt - t0), tir_pkg::LEVEL_MASK[s] ? 32'h0 : 32'h1);
      pin_set(p, 1'b0, 1'b0);
      apb(1'b1, 8'(tir_pkg::OFS_SEL_BASE + 4 * s), 32'h0);
    end
    apb(1'b1, tir_pkg::OFS_PIN_POL, 32'h0);
    $display("test routing done");
    // Port clock source table
    for (int c = 0; c < 6; c++) begin
      cs = tir_pkg::tir_clk_src_t'(c);
      p = 4'($urandom_range(5));
      apb(1'b1, tir_pkg::OFS_DIO_CLK, 32'(c) | (32'(p) << tir_pkg::CLK_BPL_LSB));
      rchk(tir_pkg::OFS_DIO_CLK, 32'h3ff);
      waitc(2);
      chk(bpl_oe, cs inside {tir_pkg::TIR_CLK_CTR0, tir_pkg::TIR_CLK_CTR1, tir_pkg::TIR_CLK_EXT} ? 32'h1 << p : 0);
    end
    // Input capture on the falling edge of the scan clock only
    apb(1'b1, tir_pkg::OFS_DIO_DIR, 32'h0);
    apb(1'b1, tir_pkg::OFS_DIO_CLK, 32'h1 << tir_pkg::CLK_IEDGE_BIT);
    apb(1'b0, tir_pkg::OFS_DIO_DATA, 32'h0);
    dv = rd[15:8] ^ 8'($urandom_range(255, 1));
    @(posedge core_clk_in);
    dio_in <= dv;
    ai_scan <= 1'b1;
    waitc(6);
    t0 = rd[15:8];
    apb(1'b0, tir_pkg::OFS_DIO_DATA, 32'h0);
    chk(rd[15:8], t0[7:0]);
    @(posedge core_clk_in);
    ai_scan <= 1'b0;
    waitc(6);
    apb(1'b0, tir_pkg::OFS_DIO_DATA, 32'h0);
    chk(rd[15:8], dv);
    $display("test port clock done");
    // Post-trigger run started by falling edge on pin 3
    apb(1'b1, tir_pkg::OFS_SEL_BASE, 32'h4);
    apb(1'b1, tir_pkg::OFS_PIN_POL, 32'h8);
    apb(1'b1, tir_pkg::OFS_POST_CNT, 32'h3);
    apb(1'b1, tir_pkg::OFS_CTRL, 32'h1 << tir_pkg::CTRL_ARM_BIT);
    k0 = kcnt;
    s0 = scnt;
    t0 = ccnt;
    repeat (2) ipulse(tir_pkg::SIG_SCAN);
    chk(32'(kcnt - k0), 32'h0);
    pin_set(4'h3, 1'b1, 1'b0);
    chk(act, 1'b1);
    repeat (5) ipulse(tir_pkg::SIG_SCAN);
    chk(32'(kcnt - k0), 32'h3);
    chk(32'(scnt - s0), 32'(ccnt - t0));
    chk({act, 32'(scnt - s0)}, {1'b0, 32'h3});
    apb(1'b1, tir_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, tir_pkg::OFS_SEL_BASE, 32'h0);
    pin_set(4'h3, 1'b0, 1'b0);
    $display("test post-trigger done");
    // Pre-trigger run, early marker must be ignored
    apb(1'b1, tir_pkg::OFS_PRE_CNT, 32'h2);
    apb(1'b1, tir_pkg::OFS_POST_CNT, 32'h2);
    k0 = kcnt;
    apb(1'b1, tir_pkg::OFS_CTRL, 32'h7);
    waitc(4);
    chk(act, 1'b1);
    ipulse(tir_pkg::SIG_SCAN);
    ipulse(tir_pkg::SIG_MARKER);
    ipulse(tir_pkg::SIG_SCAN);
    apb(1'b0, tir_pkg::OFS_STATUS, 32'h0);
    chk(rd[1:0], tir_pkg::TIR_WAIT);
    ipulse(tir_pkg::SIG_MARKER);
    repeat (3) ipulse(tir_pkg::SIG_SCAN);
    chk({act, 32'(kcnt - k0)}, {1'b0, 32'h4});
    $display("test pre-trigger done");
    wrap_up();
  end
endmodule
